/* design/spi_status_response.v */
`timescale 1ns/1ps
`include "sbc_status_map.vh"

module spi_status_response (
  input  wire                    clk,               // System clock, 50 MHz.
  input  wire                    rst_n,             // Asynchronous reset, active low.
  input  wire                    sclk,              // SPI clock pin from the host.
  input  wire                    cs_n,              // SPI chip select pin, active low.
  input  wire                    mosi,              // SPI data in from the host.
  output wire                    miso,              // SPI data out to the host.
  output wire                    miso_oe,           // Drive enable for the data out pin.
  input  wire [`LIN_CNT-1:0]     lin_wake_det,      // LIN wake detector, level pins.
  input  wire [`LIN_CNT-1:0]     lin_term_gnd,      // LIN termination short detector.
  input  wire [`LIN_CNT-1:0]     lin_over_temp,     // LIN thermal sensor above threshold.
  input  wire [`LIN_CNT-1:0]     lin_rxd_low,       // LIN receive pin shorted low.
  input  wire [`LIN_CNT-1:0]     lin_rxd_high,      // LIN receive pin shorted recessive.
  input  wire [`LIN_CNT-1:0]     lin_txd_dom,       // LIN transmit pin shorted low.
  input  wire                    int_flags_pending, // Other interrupt flags unread.
  input  wire                    wake_flags_pending,// Other wake-up flags unread.
  input  wire                    rst_flags_pending, // Reset source flags unread.
  input  wire                    can_bus_pending,   // CAN bus side flag unread.
  input  wire                    can_local_pending, // CAN local side flag unread.
  input  wire                    io_high_pending,   // I/O high sub-address flag unread.
  input  wire                    io_low_pending,    // I/O low sub-address flag unread.
  input  wire                    safe_pending,      // Fail-safe flag unread.
  input  wire                    reg_high_pending,  // Regulator high sub-address flag.
  input  wire                    reg_low_pending,   // Regulator low sub-address flag.
  output reg  [`FRAME_W-1:0]     status_word_reg,   // Registered copy of the status word.
  output reg  [`LIN_ALL_W-1:0]   lin_flags_reg,     // Registered copy of all LIN flags.
  output reg                     frame_done_reg     // Pulse after a complete frame.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam ST_IDLE  = 1'b0;  // Chip select high, output released.
  localparam ST_FRAME = 1'b1;  // Frame in progress.

  reg  [`SYNC_W-1:0]     sync1_reg;      // First synchroniser stage.
  reg  [`SYNC_W-1:0]     sync2_reg;      // Second synchroniser stage.
  wire                   cs_s;           // Synchronised chip select.
  wire                   sclk_s;         // Synchronised SPI clock.
  wire                   mosi_s;         // Synchronised data in.
  wire [`LIN_CNT-1:0]    txd_s;          // Synchronised transmit fault.
  wire [`LIN_CNT-1:0]    rxh_s;          // Synchronised receive-high fault.
  wire [`LIN_CNT-1:0]    rxl_s;          // Synchronised receive-low fault.
  wire [`LIN_CNT-1:0]    ot_s;           // Synchronised over-temperature.
  wire [`LIN_CNT-1:0]    term_s;         // Synchronised termination short.
  wire [`LIN_CNT-1:0]    wake_s;         // Synchronised wake detector.
  reg                    cs_prev_reg;    // Chip select one cycle back.
  reg                    sclk_prev_reg;  // SPI clock one cycle back.
  reg  [`LIN_CNT-1:0]    wake_prev_reg;  // Wake detector one cycle back.
  wire                   cs_fall;        // Frame start.
  wire                   cs_rise;        // Frame end.
  wire                   sclk_rise;      // Host sampling edge.
  wire [`LIN_CNT-1:0]    wake_rise;      // New wake event.
  wire [`LIN_ALL_W-1:0]  lin_flags;      // Latched LIN flags.
  wire [`LIN_ALL_W-1:0]  flag_set;       // Set causes per flag.
  wire [`LIN_ALL_W-1:0]  flag_gone;      // Recovered causes per flag.
  wire [`LIN_ALL_W-1:0]  flag_clr;       // Read-clear pulses per flag.
  wire [`LIN_FLAG_W-1:0] first_lin_source_flags;     // First LIN interface flags.
  wire [`LIN_FLAG_W-1:0] second_lin_source_flags;     // Second LIN interface flags.
  reg  [`FRAME_W-1:0]    status_comb;    // Live status word.
  reg                    state_reg;      // Frame state.
  reg                    state_next;     // Next frame state.
  reg  [`CNT_W-1:0]      cnt_reg;        // Host sampling edges seen.
  reg  [`CNT_W-1:0]      cnt_next;       // Next edge count.
  reg  [`FRAME_W-1:0]    rx_reg;         // Received frame bits.
  reg  [`FRAME_W-1:0]    rx_next;        // Next received bits.
  reg  [`FRAME_W-1:0]    tx_reg;         // Bits still to send.
  reg  [`FRAME_W-1:0]    tx_next;        // Next send bits.
  reg                    miso_reg;       // Data out flip-flop.
  reg                    miso_next;      // Next data out.
  reg  [1:0]             cmd_reg;        // Command type of the frame.
  reg  [1:0]             cmd_next;       // Next command type.
  reg  [`LIN_ALL_W-1:0]  rep_reg;        // Flags sent in this frame.
  reg  [`LIN_ALL_W-1:0]  rep_next;       // Next sent flags.
  reg  [`LIN_CNT-1:0]    clr_reg;        // Per interface read-clear pulse.
  reg  [`LIN_CNT-1:0]    clr_next;       // Next read-clear pulse.
  reg                    done_next;      // Next frame-done pulse.
  reg  [`BYTE_W-1:0]     rd_byte;        // Second byte of a read frame.
  wire                   is_read;        // Frame command is a read.
  wire                   is_write;       // Frame command is a write.
  wire [`ADDR_W-1:0]     addr_early;     // Address seen before bit 8.
  wire [`ADDR_W-1:0]     addr_final;     // Address of the whole frame.

  // --------------------------------------------------------------------------
  // Input synchronisers and edge detection
  // --------------------------------------------------------------------------

  // Every SPI and LIN pin passes two flip-flops; only the second stage is read.
  // Reset loads idle levels: select high, rest low.
  // Ones would latch every fault flag at reset exit.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= {1'b1, {`SYNC_W-1{1'b0}}};
      sync2_reg <= {1'b1, {`SYNC_W-1{1'b0}}};
    end else begin
      sync1_reg <= {cs_n, sclk, mosi, lin_txd_dom, lin_rxd_high, lin_rxd_low,
                    lin_over_temp, lin_term_gnd, lin_wake_det};
      sync2_reg <= sync1_reg;
    end
  end

  // Split the second stage into named signals.
  assign {cs_s, sclk_s, mosi_s, txd_s, rxh_s, rxl_s, ot_s, term_s, wake_s} = sync2_reg;

  // Delayed copies for edge finding on the synchronised side.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_reg   <= 1'b1;
      sclk_prev_reg <= 1'b0;
      wake_prev_reg <= {`LIN_CNT{1'b1}};
    end else begin
      cs_prev_reg   <= cs_s;
      sclk_prev_reg <= sclk_s;
      wake_prev_reg <= wake_s;
    end
  end

  // Edges come from synchronised copies, so each
  // host half period must span four clocks.
  assign cs_fall   = cs_prev_reg & ~cs_s;
  assign cs_rise   = ~cs_prev_reg & cs_s;
  assign sclk_rise = ~sclk_prev_reg & sclk_s & ~cs_s;
  assign wake_rise = wake_s & ~wake_prev_reg;

  // --------------------------------------------------------------------------
  // LIN diagnostic flags
  // --------------------------------------------------------------------------
  genvar gi;
  genvar gk;
  generate
    for (gi = 0; gi < `LIN_CNT; gi = gi + 1) begin : g_lin
      // Wake is an event and needs no recovery; faults set while present.
      assign flag_set[gi*`LIN_FLAG_W +: `LIN_FLAG_W] =
        {txd_s[gi], rxh_s[gi], rxl_s[gi], ot_s[gi], term_s[gi], wake_rise[gi]};
      assign flag_gone[gi*`LIN_FLAG_W +: `LIN_FLAG_W] =
        ~{txd_s[gi], rxh_s[gi], rxl_s[gi], ot_s[gi], term_s[gi], 1'b0};
      // Only the flags that actually went out in the read are cleared.
      assign flag_clr[gi*`LIN_FLAG_W +: `LIN_FLAG_W] =
        {`LIN_FLAG_W{clr_reg[gi]}} & rep_reg[gi*`LIN_FLAG_W +: `LIN_FLAG_W];
      for (gk = 0; gk < `LIN_FLAG_W; gk = gk + 1) begin : g_flag
        // Sticky cell: clears on read only once the cause is gone.
        flag_cell u_flag (
          .clk       (clk),
          .rst_n     (rst_n),
          .set_in    (flag_set[gi*`LIN_FLAG_W+gk]),
          .cond_gone (flag_gone[gi*`LIN_FLAG_W+gk]),
          .clr_in    (flag_clr[gi*`LIN_FLAG_W+gk]),
          .flag_reg  (lin_flags[gi*`LIN_FLAG_W+gk])
        );
      end
    end
  endgenerate

  // First interface in the low six bits, second above.
  assign first_lin_source_flags = lin_flags[`LIN_FLAG_W-1:0];
  assign second_lin_source_flags = lin_flags[`LIN_ALL_W-1:`LIN_FLAG_W];

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------

  // The word is a pure function of the latched flags and pending inputs, so it drops as soon
  // as the last contributing flag has been read away.
  always @* begin
    status_comb = {`FRAME_W{1'b0}};
    // Wake flags stay out of the interrupt summary; they feed the wake, LIN group and LIN source bits.
    status_comb[`ST_INT] = int_flags_pending | (|(lin_flags & ~{
      {`LIN_FLAG_W-1{1'b0}}, 1'b1, {`LIN_FLAG_W-1{1'b0}}, 1'b1}));
    status_comb[`ST_WU] = wake_flags_pending | first_lin_source_flags[`LF_WAKE]
                          | second_lin_source_flags[`LF_WAKE];
    status_comb[`ST_RST] = rst_flags_pending;
    status_comb[`ST_CAN_G] = can_bus_pending | can_local_pending;
    status_comb[`ST_LIN_G] = (|first_lin_source_flags) | (|second_lin_source_flags);
    status_comb[`ST_IO_G] = io_high_pending | io_low_pending;
    status_comb[`ST_SAFE_G] = safe_pending;
    status_comb[`ST_REG_G] = reg_high_pending | reg_low_pending;
    status_comb[`ST_CAN_BUS] = can_bus_pending;
    status_comb[`ST_CAN_LOCAL_SIDE_SOURCE] = can_local_pending;
    status_comb[`ST_SECOND_LIN_SOURCE] = |second_lin_source_flags;
    status_comb[`ST_FIRST_LIN_SOURCE] = |first_lin_source_flags;
    status_comb[`ST_IO_HI] = io_high_pending;
    status_comb[`ST_IO_LO] = io_low_pending;
    status_comb[`ST_REG_HI] = reg_high_pending;
    status_comb[`ST_REG_LO] = reg_low_pending;
  end

  // --------------------------------------------------------------------------
  // SPI frame engine
  // --------------------------------------------------------------------------
  // Codes 00 and 11 read; 10 neither reads nor writes.
  assign is_read    = (cmd_reg == `CMD_READ_LO) || (cmd_reg == `CMD_READ_HI);
  assign is_write   = (cmd_reg == `CMD_WRITE);
  assign addr_early = rx_reg[`ADDR_W-1:0];
  assign addr_final = rx_reg[`FRAME_W-3:`FRAME_W-2-`ADDR_W];

  // Second byte of a read: the addressed LIN flag register, else zero.
  // Bits 7-6 of the flag byte always read zero.
  always @* begin
    rd_byte = {`BYTE_W{1'b0}};
    if (addr_early == `ADDR_FIRST_LIN) begin
      rd_byte[`LIN_FLAG_W-1:0] = first_lin_source_flags;
    end else if (addr_early == `ADDR_SECOND_LIN) begin
      rd_byte[`LIN_FLAG_W-1:0] = second_lin_source_flags;
    end
  end

  // Frame sequencing: load status at select, shift on each sampling edge.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    miso_next  = miso_reg;
    cmd_next   = cmd_reg;
    rep_next   = rep_reg;
    clr_next   = {`LIN_CNT{1'b0}};
    done_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          // Fixed byte first, extended byte queued behind it.
          state_next = ST_FRAME;
          cnt_next   = {`CNT_W{1'b0}};
          rx_next    = {`FRAME_W{1'b0}};
          tx_next    = status_comb;
          miso_next  = status_comb[`FRAME_W-1];
          rep_next   = {`LIN_ALL_W{1'b0}};
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          // Only a complete read of a LIN register clears its flags.
          state_next = ST_IDLE;
          miso_next  = 1'b0;
          if (cnt_reg == `FRAME_BITS) begin
            done_next = 1'b1;
            if (is_read && (addr_final == `ADDR_FIRST_LIN)) begin
              clr_next[0] = 1'b1;
            end else if (is_read && (addr_final == `ADDR_SECOND_LIN)) begin
              clr_next[1] = 1'b1;
            end
          end
        end else if (sclk_rise && (cnt_reg != `FRAME_BITS)) begin
          // Rises past the sixteenth are ignored.
          cnt_next = cnt_reg + 1'b1;
          rx_next  = {rx_reg[`FRAME_W-2:0], mosi_s};
          tx_next  = {tx_reg[`FRAME_W-2:0], 1'b0};
          if (cnt_reg == `SECOND_BIT) begin
            cmd_next = {rx_reg[0], mosi_s};
          end
          if ((cnt_reg == `LAST_HI_BIT) && !is_write) begin
            // Not a write: the extended byte is withheld.
            tx_next = {{`BYTE_W{1'b0}}, {`BYTE_W{1'b0}}};
            if (is_read) begin
              tx_next[`FRAME_W-1:`BYTE_W] = rd_byte;
              if (addr_early == `ADDR_FIRST_LIN) begin
                rep_next[`LIN_FLAG_W-1:0] = first_lin_source_flags;
              end else if (addr_early == `ADDR_SECOND_LIN) begin
                rep_next[`LIN_ALL_W-1:`LIN_FLAG_W] = second_lin_source_flags;
              end
            end
          end
          miso_next = tx_next[`FRAME_W-1];
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // The clear pulse lands one cycle after frame end,
  // once the host has taken the flag byte.
  // Frame engine registers.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= {`CNT_W{1'b0}};
      rx_reg         <= {`FRAME_W{1'b0}};
      tx_reg         <= {`FRAME_W{1'b0}};
      miso_reg       <= 1'b0;
      cmd_reg        <= `CMD_READ_LO;
      rep_reg        <= {`LIN_ALL_W{1'b0}};
      clr_reg        <= {`LIN_CNT{1'b0}};
      frame_done_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      rx_reg         <= rx_next;
      tx_reg         <= tx_next;
      miso_reg       <= miso_next;
      cmd_reg        <= cmd_next;
      rep_reg        <= rep_next;
      clr_reg        <= clr_next;
      frame_done_reg <= done_next;
    end
  end

  // --------------------------------------------------------------------------
  // Observation outputs
  // --------------------------------------------------------------------------

  // Registered copies for the rest of the chip.
  // Both copies lag the live values by one clock.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word_reg <= {`FRAME_W{1'b0}};
      lin_flags_reg   <= {`LIN_ALL_W{1'b0}};
    end else begin
      status_word_reg <= status_comb;
      lin_flags_reg   <= lin_flags;
    end
  end

  // The data pin is driven only while a frame is open.
  assign miso    = miso_reg;
  assign miso_oe = (state_reg == ST_FRAME);

endmodule // spi_status_response

/* design/sbc_status_map.vh */
`ifndef SBC_STATUS_MAP_VH
`define SBC_STATUS_MAP_VH

// ----------------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------------
`define FRAME_W        16
`define BYTE_W         8
`define CNT_W          5
`define FRAME_BITS     5'h10
`define LAST_HI_BIT    5'h07
`define SECOND_BIT     5'h01
`define ADDR_W         5

// ----------------------------------------------------------------------------
// Command type encodings carried in frame bits 15-14
// ----------------------------------------------------------------------------
`define CMD_READ_LO    2'h0
`define CMD_READ_HI    2'h3
`define CMD_WRITE      2'h1

// ----------------------------------------------------------------------------
// Addresses of the two LIN flag registers (frame bits 13-9)
// ----------------------------------------------------------------------------
`define ADDR_FIRST_LIN  5'h13
`define ADDR_SECOND_LIN 5'h14

// ----------------------------------------------------------------------------
// LIN flag byte layout and sizes
// ----------------------------------------------------------------------------
`define LIN_CNT        2
`define LIN_FLAG_W     6
`define LIN_ALL_W      12
`define LF_WAKE        0
`define LF_TERM        1
`define LF_OTEMP       2
`define LF_RXD_LOW     3
`define LF_RXD_HIGH    4
`define LF_TXD_DOM     5
`define SYNC_W         15

// ----------------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------------
`define ST_INT         15
`define ST_WU          14
`define ST_RST         13
`define ST_CAN_G       12
`define ST_LIN_G       11
`define ST_IO_G        10
`define ST_SAFE_G      9
`define ST_REG_G       8
`define ST_CAN_BUS     7
`define ST_CAN_LOCAL_SIDE_SOURCE     6
`define ST_SECOND_LIN_SOURCE        5
`define ST_FIRST_LIN_SOURCE        4
`define ST_IO_HI       3
`define ST_IO_LO       2
`define ST_REG_HI      1
`define ST_REG_LO      0

`endif

/* design/flag_cell.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Sticky diagnostic flag with read-to-clear once the cause has gone.
// ----------------------------------------------------------------------------
module flag_cell (
  input  wire clk,        // System clock.
  input  wire rst_n,      // Asynchronous reset, active low.
  input  wire set_in,     // Cause present or event seen this cycle.
  input  wire cond_gone,  // High when the cause has recovered.
  input  wire clr_in,     // One-cycle read-clear pulse for this flag.
  output reg  flag_reg    // Latched flag value.
);

  reg flag_next;  // Next flag value.

  // A set always wins over a clear arriving in the same cycle.
  always @* begin
    flag_next = flag_reg;
    if (set_in) begin
      flag_next = 1'b1;
    end else if (clr_in && cond_gone) begin
      flag_next = 1'b0;
    end
  end

  // Flag storage, cleared by reset.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule // flag_cell

/* bench/spi_host_model.sv */
`timescale 1ns/1ps

// ------
// Host model: SPI mode 0 master, 160 ns bit period, MSB first.
// ------
module spi_host_model (
  input  wire  clk,  // System clock; every edge is placed on its falling edge.
  output logic sclk, // Serial clock, held low outside frames.
  output logic cs_n, // Chip select, active low.
  output logic mosi, // Serial data to the device.
  input  wire  miso  // Serial data from the device.
);
  // The lines start idle.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Waits a number of falling clock edges.
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Sends nbits of cmd and samples the reply at each rising sclk edge.
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] resp);
    int i;
    resp = 16'h0000;
    cs_n = 1'b0;
    mosi = cmd[15];
    hold(8);
    for (i = 15; i > 15 - nbits; i--) begin
      sclk = 1'b1;
      resp[i] = miso;
      hold(4);
      sclk = 1'b0;
      if (i > 0) mosi = cmd[i-1];
      hold(4);
    end
    cs_n = 1'b1;
    // The released data line must not keep showing its last bit.
    mosi = ~mosi;
    hold(8);
  endtask
endmodule // spi_host_model

/* bench/spi_status_response_asserts.sv */
`timescale 1ns/1ps
`include "sbc_status_map.vh"

// ------
// Checker on the status block ports.
// ------
module spi_status_response_asserts (
  input wire                  clk,                // System clock.
  input wire                  rst_n,              // Reset, active low.
  input wire                  cs_n,               // Chip select pin.
  input wire                  miso_oe,            // Data out enable.
  input wire                  int_flags_pending,  // Interrupt flags unread.
  input wire                  wake_flags_pending, // Wake-up flags unread.
  input wire                  rst_flags_pending,  // Reset flags unread.
  input wire                  can_bus_pending,    // CAN bus side flag.
  input wire                  can_local_pending,  // CAN local side flag.
  input wire                  io_high_pending,    // I/O high flag.
  input wire                  io_low_pending,     // I/O low flag.
  input wire                  safe_pending,       // Fail-safe flag.
  input wire                  reg_high_pending,   // Regulator high flag.
  input wire                  reg_low_pending,    // Regulator low flag.
  input wire [`FRAME_W-1:0]   status_word_reg,    // Status word copy.
  input wire [`LIN_ALL_W-1:0] lin_flags_reg,      // LIN flags copy.
  input wire                  frame_done_reg      // Frame end pulse.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_int_summary: assert property (int_flags_pending |=> status_word_reg[`ST_INT])
    else $error("interrupt summary bit missing");
  chk_wake_summary: assert property (wake_flags_pending |=> status_word_reg[`ST_WU])
    else $error("wake summary bit missing");
  chk_reset_summary: assert property ($past(rst_n) |->
    status_word_reg[`ST_RST] == $past(rst_flags_pending)) else $error("reset bit wrong");
  chk_can_group: assert property ($past(rst_n) |-> status_word_reg[`ST_CAN_G] ==
    $past(can_bus_pending | can_local_pending)) else $error("CAN group bit wrong");
  chk_other_groups: assert property ($past(rst_n) |-> status_word_reg[10:8] ==
    $past({io_high_pending | io_low_pending, safe_pending, reg_high_pending | reg_low_pending}))
    else $error("group bits wrong");
  chk_ext_sources: assert property ($past(rst_n) |-> {status_word_reg[7:6],
    status_word_reg[3:0]} == $past({can_bus_pending, can_local_pending, io_high_pending,
    io_low_pending, reg_high_pending, reg_low_pending})) else $error("source bits wrong");
  chk_lin_sources: assert property ($stable(lin_flags_reg) && $past(rst_n) |->
    {status_word_reg[`ST_LIN_G], status_word_reg[5:4]} == {|lin_flags_reg,
    |lin_flags_reg[11:6], |lin_flags_reg[5:0]}) else $error("LIN source bits wrong");
  chk_clear_on_read: assert property (|($past(lin_flags_reg) & ~lin_flags_reg) |->
    $past(frame_done_reg) || $past(frame_done_reg, 2) || $past(frame_done_reg, 3))
    else $error("LIN flag cleared without a read");
  chk_select_oe: assert property ($fell(cs_n) |-> ##[2:6] miso_oe)
    else $error("data out not enabled after select");

  cover property (frame_done_reg);
  cover property ($fell(lin_flags_reg[0]));
  cover property (status_word_reg[`ST_INT] && status_word_reg[`ST_LIN_G]);
endmodule // spi_status_response_asserts

bind spi_status_response spi_status_response_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .miso_oe(miso_oe),
  .int_flags_pending(int_flags_pending), .wake_flags_pending(wake_flags_pending),
  .rst_flags_pending(rst_flags_pending), .can_bus_pending(can_bus_pending),
  .can_local_pending(can_local_pending), .io_high_pending(io_high_pending),
  .io_low_pending(io_low_pending), .safe_pending(safe_pending),
  .reg_high_pending(reg_high_pending), .reg_low_pending(reg_low_pending),
  .status_word_reg(status_word_reg), .lin_flags_reg(lin_flags_reg),
  .frame_done_reg(frame_done_reg));

/* bench/spi_status_response_tb_top.sv */
`timescale 1ns/1ps

module spi_status_response_tb_top;
  // ------
  // Signals
  // ------
  logic        clk;         // System clock.
  logic        rst_n;       // Reset, active low.
  wire         sclk;        // Serial clock.
  wire         cs_n;        // Chip select.
  wire         mosi;        // Data to the device.
  wire         miso;        // Data from the device.
  logic [9:0]  pend;        // Summary source inputs.
  logic [1:0]  wake;        // LIN wake levels.
  logic [1:0]  flt [1:5];   // LIN fault levels by flag bit.
  wire  [15:0] status_word; // Registered status word.
  wire  [11:0] lin_flags;   // Registered LIN flags.
  wire         miso_oe;     // Data out enable.
  wire         frame_done;  // Frame end pulse.
  int          n_done;      // Frame ends seen.
  logic [15:0] resp;        // Last reply.
  int          err_count;   // Mismatches.
  int          n_compared;  // Comparisons.
  // Word expected for each summary source alone.
  logic [15:0] src_word [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1080, 16'h1040,
                                 16'h0408, 16'h0404, 16'h0200, 16'h0102, 16'h0101};

  spi_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  spi_status_response dut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .lin_wake_det(wake), .lin_term_gnd(flt[1]), .lin_over_temp(flt[2]),
    .lin_rxd_low(flt[3]), .lin_rxd_high(flt[4]), .lin_txd_dom(flt[5]),
    .int_flags_pending(pend[0]), .wake_flags_pending(pend[1]), .rst_flags_pending(pend[2]),
    .can_bus_pending(pend[3]), .can_local_pending(pend[4]), .io_high_pending(pend[5]),
    .io_low_pending(pend[6]), .safe_pending(pend[7]), .reg_high_pending(pend[8]),
    .reg_low_pending(pend[9]), .status_word_reg(status_word), .lin_flags_reg(lin_flags),
    .frame_done_reg(frame_done));

  // Counts frame end pulses.
  always @(posedge clk) if (frame_done) n_done <= n_done + 1;

  // ------
  // Tasks
  // ------
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Each source alone shows in both reply bytes of a write, first byte of reads.
  task automatic sc_sources();
    for (int k = 0; k < 10; k++) begin
      pend = 10'h001 << k;
      host.hold(3);
      host.xfer(16'h4000, 16, resp);
      check("write reply", src_word[k], resp);
      check("data out released", 16'h0000, {15'h0000, miso_oe});
      check("status word", src_word[k], status_word);
      host.xfer(16'h0000, 16, resp);
      check("read 00 reply", {src_word[k][15:8], 8'h00}, resp);
      host.xfer(16'hC000, 16, resp);
      check("read 11 reply", {src_word[k][15:8], 8'h00}, resp);
    end
    pend = 10'h000;
  endtask

  // Wake flag: kept over a short frame, cleared by a full read while the level stays.
  task automatic sc_wake();
    for (int n = 0; n < 2; n++) begin
      wake = 2'b01 << n;
      host.hold(6);
      check("wake flag", 16'h0001 << (6 * n), {4'h0, lin_flags});
      host.xfer(n ? 16'h2980 : 16'h2780, 12, resp);
      host.hold(4);
      check("flag after short frame", 16'h0001 << (6 * n), {4'h0, lin_flags});
      check("frame ends", 16'(30 + n), 16'(n_done));
      host.xfer(n ? 16'h2980 : 16'h2780, 16, resp);
      check("wake read", 16'h4801, resp);
      host.hold(4);
      check("wake cleared", 16'h0000, {4'h0, lin_flags});
    end
    wake = 2'b00;
  endtask

  // Faults stay over a read while present and clear after recovery plus a read.
  task automatic sc_faults();
    for (int n = 0; n < 2; n++) for (int b = 1; b < 6; b++) begin
      flt[b] = 2'b01 << n;
      host.hold(6);
      host.xfer(n ? 16'h2980 : 16'h2780, 16, resp);
      check("fault read", 16'h8800 | (16'h0001 << b), resp);
      host.hold(4);
      check("fault held", 16'h0001 << (b + 6 * n), {4'h0, lin_flags});
      flt[b] = 2'b00;
      host.hold(6);
      host.xfer(n ? 16'h2980 : 16'h2780, 16, resp);
      check("recovered read", 16'h8800 | (16'h0001 << b), resp);
      host.hold(4);
      check("fault cleared", 16'h0000, {4'h0, lin_flags});
    end
  endtask

  // ------
  // Clock, sequence and watchdog
  // ------
  // Free running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Resets the block, then runs the scenarios.
  initial begin
    rst_n = 1'b0;
    pend = 10'h000;
    wake = 2'b00;
    foreach (flt[i]) flt[i] = 2'b00;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    host.hold(4);
    check("status after reset", 16'h0000, status_word);
    sc_sources();
    sc_wake();
    sc_faults();
    conclude();
  end

  // Cuts a hung run short.
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
endmodule // spi_status_response_tb_top
